// ==== hw/single_channel_timer_regs.sv ====
/*
 Single-channel 16-bit timer: prescaler, up counter with reload, one capture or
 compare channel with preload, input remap and a plain register port.
 Assumes external inputs are asynchronous and the register master follows the
 one-cycle strobe protocol with read data in the next cycle.
*/
// Chosen here: strobed register access.
`timescale 1ns/1ns
module single_channel_timer_regs #(
   parameter int W = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] addr_i,
   input wire logic [W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [W-1:0] rdata_o,
   input wire logic chan1_pin_i,
   input wire logic chan2_pin_i,
   input wire logic internal_trigger_i,
   input wire logic rtc_clock_source_i,
   input wire logic external_oscillator_clock_i,
   input wire logic clock_output_signal_i,
   output logic chan1_output_o,
   output logic output_drive_enable_o,
   output logic update_event_o
);

   typedef struct packed {
      logic en;
      logic pol;
      logic pol_aux;
      logic [1:0] dir;
      logic pren;
      logic [W-1:0] cnt;
      logic [W-1:0] prescale_divider;
      logic [W-1:0] psc_sh;
      logic [W-1:0] pcnt;
      logic [W-1:0] arr;
      logic [W-1:0] ccr;
      logic [W-1:0] ccr_pre;
      logic [1:0] rmp;
      logic [4:0] osc_cnt;
      logic osc_div;
      logic out;
      logic oe;
      logic upd;
      logic [W-1:0] rdata;
   } timer_state_t;

   timer_state_t state_ff;
   timer_state_t nxt_state;

   ////////////////////////////////////////////////////////////////////////////
   // Synchronised external inputs.
   logic pin_rise, pin_fall, in2_rise, in2_fall, trg_rise, trg_fall;
   logic rtc_rise, rtc_fall, osc_rise, osc_fall, mco_rise, mco_fall;

   input_conditioner u_pin (
      .clk_i(clk_i), .rst_i(rst_i), .async_i(chan1_pin_i), .rise_o(pin_rise), .fall_o(pin_fall)
   );
   input_conditioner u_in2 (
      .clk_i(clk_i), .rst_i(rst_i), .async_i(chan2_pin_i), .rise_o(in2_rise), .fall_o(in2_fall)
   );
   input_conditioner u_trg (
      .clk_i(clk_i), .rst_i(rst_i), .async_i(internal_trigger_i), .rise_o(trg_rise), .fall_o(trg_fall)
   );
   input_conditioner u_rtc (
      .clk_i(clk_i), .rst_i(rst_i), .async_i(rtc_clock_source_i), .rise_o(rtc_rise), .fall_o(rtc_fall)
   );
   input_conditioner u_osc (
      .clk_i(clk_i), .rst_i(rst_i), .async_i(external_oscillator_clock_i), .rise_o(osc_rise),
      .fall_o(osc_fall)
   );
   input_conditioner u_mco (
      .clk_i(clk_i), .rst_i(rst_i), .async_i(clock_output_signal_i), .rise_o(mco_rise), .fall_o(mco_fall)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Oscillator clock divided by 32: the level toggles every 16 rising oscillator edges.
   logic osc_wrap, div_rise, div_fall;
   assign osc_wrap = osc_rise && (state_ff.osc_cnt == timer_pkg::OSC_HALF_LAST);
   assign div_rise = osc_wrap && !state_ff.osc_div;
   assign div_fall = osc_wrap && state_ff.osc_div;

   // Remap of timer input one.
   logic in1_rise, in1_fall;
   always_comb begin
      unique case (state_ff.rmp)
         timer_pkg::REMAP_PIN: begin
            in1_rise = pin_rise;
            in1_fall = pin_fall;
         end
         timer_pkg::REMAP_RTC: begin
            in1_rise = rtc_rise;
            in1_fall = rtc_fall;
         end
         timer_pkg::REMAP_OSC_DIV: begin
            in1_rise = div_rise;
            in1_fall = div_fall;
         end
         timer_pkg::REMAP_CLOCK_OUT: begin
            in1_rise = mco_rise;
            in1_fall = mco_fall;
         end
      endcase
   end

   // Capture source chosen by the direction field.
   logic src_rise, src_fall;
   always_comb begin
      unique case (state_ff.dir)
         timer_pkg::DIR_OUTPUT: begin
            src_rise = 1'b0;
            src_fall = 1'b0;
         end
         timer_pkg::DIR_OWN_INPUT: begin
            src_rise = in1_rise;
            src_fall = in1_fall;
         end
         timer_pkg::DIR_NEIGHBOUR_INPUT: begin
            src_rise = in2_rise;
            src_fall = in2_fall;
         end
         timer_pkg::DIR_TRIGGER_INPUT: begin
            src_rise = trg_rise;
            src_fall = trg_fall;
         end
      endcase
   end

   // Edge selection by the polarity pair; the unlisted code 10 acts as rising.
   logic edge_hit, capture;
   always_comb begin
      unique case ({state_ff.pol_aux, state_ff.pol})
         timer_pkg::EDGE_FALLING: edge_hit = src_fall;
         timer_pkg::EDGE_BOTH: edge_hit = src_rise | src_fall;
         default: edge_hit = src_rise;
      endcase
   end
   assign capture = edge_hit && state_ff.en && (state_ff.dir != timer_pkg::DIR_OUTPUT);

   ////////////////////////////////////////////////////////////////////////////
   // Time base decode.
   logic tick, wrap, wr_cnt, wr_ccr, out_mode, cmp_ref;
   assign tick = (state_ff.pcnt == state_ff.psc_sh);
   assign wrap = tick && (state_ff.arr != '0) && (state_ff.cnt == state_ff.arr);
   assign wr_cnt = wr_i && (addr_i == timer_pkg::OFF_COUNTER_VALUE);
   assign wr_ccr = wr_i && (addr_i == timer_pkg::OFF_CHANNEL1_VALUE);
   assign out_mode = (state_ff.dir == timer_pkg::DIR_OUTPUT);
   assign cmp_ref = (state_ff.cnt < state_ff.ccr);

   // Read data for an address, zero for reserved bits and unmapped offsets.
   function automatic logic [W-1:0] read_reg(input timer_state_t s, input logic [7:0] a);
      logic [W-1:0] v;
      v = '0;
      unique case (a)
         timer_pkg::OFF_CHANNEL_MODE: begin
            v[timer_pkg::POS_DIRECTION_LSB +: 2] = s.dir;
            v[timer_pkg::POS_PRELOAD_ENABLE] = s.pren;
         end
         timer_pkg::OFF_CHANNEL_ENABLE_POLARITY: begin
            v[timer_pkg::POS_CHAN1_ENABLE] = s.en;
            v[timer_pkg::POS_CHAN1_POLARITY] = s.pol;
            v[timer_pkg::POS_CHAN1_POLARITY_AUX] = s.pol_aux;
         end
         timer_pkg::OFF_COUNTER_VALUE: v = s.cnt;
         timer_pkg::OFF_PRESCALE_DIVIDER: v = s.prescale_divider;
         timer_pkg::OFF_RELOAD_VALUE: v = s.arr;
         timer_pkg::OFF_CHANNEL1_VALUE: v = s.ccr;
         timer_pkg::OFF_INPUT_REMAP_OPTION: v[timer_pkg::POS_REMAP_LSB +: 2] = s.rmp;
         default: v = '0;
      endcase
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic for registers, time base, channel and outputs.
   always_comb begin
      nxt_state = state_ff;
      nxt_state.upd = 1'b0;
      nxt_state.rdata = rd_i ? read_reg(state_ff, addr_i) : '0;
      // Divided oscillator.
      if (osc_rise) begin
         nxt_state.osc_cnt = osc_wrap ? 5'h00 : state_ff.osc_cnt + 5'h01;
      end
      if (osc_wrap) begin
         nxt_state.osc_div = ~state_ff.osc_div;
      end
      // Prescaler and counter.
      nxt_state.pcnt = tick ? '0 : state_ff.pcnt + 1'b1;
      if (tick && state_ff.arr != '0) begin
         nxt_state.cnt = wrap ? '0 : state_ff.cnt + 1'b1;
      end
      if (wrap) begin
         nxt_state.upd = 1'b1;
         nxt_state.psc_sh = state_ff.prescale_divider;
         if (out_mode && state_ff.pren) begin
            nxt_state.ccr = state_ff.ccr_pre;
         end
      end
      // Software writes; reserved bits are dropped.
      if (wr_i) begin
         unique case (addr_i)
            timer_pkg::OFF_CHANNEL_MODE: begin
               nxt_state.dir = wdata_i[timer_pkg::POS_DIRECTION_LSB +: 2];
               nxt_state.pren = wdata_i[timer_pkg::POS_PRELOAD_ENABLE];
            end
            timer_pkg::OFF_CHANNEL_ENABLE_POLARITY: begin
               nxt_state.en = wdata_i[timer_pkg::POS_CHAN1_ENABLE];
               nxt_state.pol = wdata_i[timer_pkg::POS_CHAN1_POLARITY];
               nxt_state.pol_aux = wdata_i[timer_pkg::POS_CHAN1_POLARITY_AUX];
            end
            timer_pkg::OFF_COUNTER_VALUE: nxt_state.cnt = wdata_i;
            timer_pkg::OFF_PRESCALE_DIVIDER: nxt_state.prescale_divider = wdata_i;
            timer_pkg::OFF_RELOAD_VALUE: nxt_state.arr = wdata_i;
            timer_pkg::OFF_CHANNEL1_VALUE: begin
               nxt_state.ccr_pre = wdata_i;
               if (!(out_mode && state_ff.pren)) begin
                  nxt_state.ccr = wdata_i;
               end
            end
            timer_pkg::OFF_INPUT_REMAP_OPTION: nxt_state.rmp = wdata_i[timer_pkg::POS_REMAP_LSB +: 2];
            default: nxt_state.rmp = state_ff.rmp;
         endcase
      end
      // A capture wins over a software write in the same cycle.
      if (capture) begin
         nxt_state.ccr = state_ff.cnt;
      end
      // Output stage.
      if (out_mode && state_ff.en) begin
         nxt_state.out = cmp_ref ^ state_ff.pol;
         nxt_state.oe = 1'b1;
      end else begin
         nxt_state.out = 1'b0;
         nxt_state.oe = 1'b0;
      end
   end

   // Registers the whole state.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff <= '0;
         state_ff.arr <= timer_pkg::RST_RELOAD_VALUE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign rdata_o = state_ff.rdata;
   assign chan1_output_o = state_ff.out;
   assign output_drive_enable_o = state_ff.oe;
   assign update_event_o = state_ff.upd;

   ////////////////////////////////////////////////////////////////////////////
   // Checks on the channel, the time base and the register port.
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_output_disabled: assert property (!(out_mode && state_ff.en) |=> !chan1_output_o && !output_drive_enable_o)
      else $error("Output driven while channel disabled.");

   a_output_level: assert property ((out_mode && state_ff.en) |=>
      output_drive_enable_o && (chan1_output_o == ($past(cmp_ref) ^ $past(state_ff.pol))))
      else $error("Enabled output does not follow reference and polarity.");

   a_active_low: assert property ((out_mode && state_ff.en && state_ff.pol && cmp_ref) |=> !chan1_output_o)
      else $error("Active-low output not inverted.");

   a_capture_gated: assert property ((!out_mode && !state_ff.en && !wr_ccr) |=> $stable(state_ff.ccr))
      else $error("Channel value changed with capture disabled.");

   a_capture_value: assert property (capture |=> state_ff.ccr == $past(state_ff.cnt))
      else $error("Capture did not latch the counter.");

   a_falling_edge: assert property (({state_ff.pol_aux, state_ff.pol} == timer_pkg::EDGE_FALLING && capture)
      |-> src_fall)
      else $error("Falling-edge capture without a falling edge.");

   a_direct_write: assert property ((wr_ccr && !capture && !(out_mode && state_ff.pren)) |=>
      state_ff.ccr == $past(wdata_i))
      else $error("Direct channel write not applied.");

   a_preload_hold: assert property ((out_mode && state_ff.pren && !wrap) |=> $stable(state_ff.ccr))
      else $error("Preloaded compare value applied before update.");

   a_reload_stop: assert property ((state_ff.arr == '0 && !wr_cnt) |=> $stable(state_ff.cnt))
      else $error("Counter advanced with zero reload value.");

   a_wrap_update: assert property ((wrap && !wr_cnt) |=> state_ff.cnt == '0 && update_event_o)
      else $error("Counter wrap did not clear and signal update.");

   a_tick_divide: assert property ((state_ff.psc_sh == 16'h0003 && tick && !wrap) |=> !tick [*3] ##1 tick)
      else $error("Prescaler does not divide by value plus one.");

   a_remap_rtc: assert property ((state_ff.rmp == timer_pkg::REMAP_RTC) |-> in1_rise == rtc_rise)
      else $error("Remap does not route the rtc clock.");

   a_reserved_zero: assert property ((rd_i && addr_i == timer_pkg::OFF_CHANNEL_ENABLE_POLARITY) |=>
      rdata_o[15:4] == 12'h000 && !rdata_o[2])
      else $error("Reserved bits read as nonzero.");

   c_capture: cover property (capture);
   c_wrap: cover property (wrap);
   c_preload_apply: cover property (out_mode && state_ff.pren && wrap);
   c_output_on: cover property (output_drive_enable_o && chan1_output_o);

endmodule

// ==== hw/timer_pkg.sv ====
/*
 Constants of the single-channel 16-bit timer: register offsets, field positions,
 reset values, selector encodings and clock figures.
 Assumes a byte-addressed register port and a 10 MHz core clock.
*/
package timer_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Clock figures.
   localparam int CLK_PERIOD_NS = 100;
   localparam int OSC_DIVIDE = 32;
   localparam logic [4:0] OSC_HALF_LAST = 5'(OSC_DIVIDE / 2 - 1);

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets.
   localparam logic [7:0] OFF_CHANNEL_MODE = 8'h18;
   localparam logic [7:0] OFF_CHANNEL_ENABLE_POLARITY = 8'h20;
   localparam logic [7:0] OFF_COUNTER_VALUE = 8'h24;
   localparam logic [7:0] OFF_PRESCALE_DIVIDER = 8'h28;
   localparam logic [7:0] OFF_RELOAD_VALUE = 8'h2c;
   localparam logic [7:0] OFF_CHANNEL1_VALUE = 8'h34;
   localparam logic [7:0] OFF_INPUT_REMAP_OPTION = 8'h50;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions.
   localparam int POS_CHAN1_ENABLE = 0;
   localparam int POS_CHAN1_POLARITY = 1;
   localparam int POS_CHAN1_POLARITY_AUX = 3;
   localparam int POS_DIRECTION_LSB = 0;
   localparam int POS_PRELOAD_ENABLE = 3;
   localparam int POS_REMAP_LSB = 0;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values.
   localparam logic [15:0] RST_ZERO = 16'h0000;
   localparam logic [15:0] RST_RELOAD_VALUE = 16'hffff;

   ////////////////////////////////////////////////////////////////////////////
   // Selector encodings.
   localparam logic [1:0] DIR_OUTPUT = 2'h0;
   localparam logic [1:0] DIR_OWN_INPUT = 2'h1;
   localparam logic [1:0] DIR_NEIGHBOUR_INPUT = 2'h2;
   localparam logic [1:0] DIR_TRIGGER_INPUT = 2'h3;
   localparam logic [1:0] REMAP_PIN = 2'h0;
   localparam logic [1:0] REMAP_RTC = 2'h1;
   localparam logic [1:0] REMAP_OSC_DIV = 2'h2;
   localparam logic [1:0] REMAP_CLOCK_OUT = 2'h3;
   localparam logic [1:0] EDGE_RISING = 2'h0;
   localparam logic [1:0] EDGE_FALLING = 2'h1;
   localparam logic [1:0] EDGE_BOTH = 2'h3;

endpackage

// ==== hw/input_conditioner.sv ====
/*
 Three-stage synchroniser for one asynchronous input, with a debounced level
 and one-cycle rise and fall pulses.
 Assumes the input changes slower than half the core clock rate.
*/
`timescale 1ns/1ns
module input_conditioner (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic async_i,
   output logic rise_o,
   output logic fall_o
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic level;
   } cond_state_t;

   cond_state_t state_ff;
   cond_state_t nxt_state;

   // A change counts once the second and third stages agree on it.
   always_comb begin
      nxt_state = state_ff;
      nxt_state.s1 = async_i;
      nxt_state.s2 = state_ff.s1;
      nxt_state.s3 = state_ff.s2;
      if (state_ff.s2 == state_ff.s3) begin
         nxt_state.level = state_ff.s3;
      end
   end

   // Registers the whole state.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         nxt_state_reset: state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Edges are taken from the agreed stages only.
   assign rise_o = state_ff.s2 & state_ff.s3 & ~state_ff.level;
   assign fall_o = ~state_ff.s2 & ~state_ff.s3 & state_ff.level;

endmodule

// ==== tb/pin_source.sv ====
/*
 Far-side model of the timer's input sources: channel pin, neighbouring input,
 internal trigger, rtc clock, clock output and a free-running oscillator.
 Assumes the bench selects one source at a time and lowers it before moving on.
*/
`timescale 1ns/1ns
module pin_source (
   input wire logic [2:0] sel_i,
   input wire logic lvl_i,
   input wire logic osc_run_i,
   output logic [4:0] line_o,
   output logic osc_o
);
   ////////////////////////////////////////////////////////////////////////////
   // Only the selected source follows the bench level; idle sources rest low.
   always_comb begin
      line_o = 5'h00;
      line_o[sel_i] = lvl_i;
   end

   ////////////////////////////////////////////////////////////////////////////
   // The oscillator runs on its own period so its phase drifts against the core clock.
   initial begin
      osc_o = 1'b0;
      forever begin
         #430;
         osc_o = osc_run_i ? ~osc_o : 1'b0;
      end
   end
endmodule

// ==== tb/single_channel_timer_regs_tb.sv ====
/*
 Self-checking bench of the single-channel timer: register map, time base,
 compare output, capture from every source and the prescaler.
 Assumes the pin_source model on the inputs and a 10 MHz core clock.
*/
`timescale 1ns/1ns
`define CHK(g, x) begin num_checks++; if ((g) !== (x)) begin bad_count++; \
   $display("Error at %0t ns: got %h, want %h", $time, g, x); end end
module single_channel_timer_regs_tb;
   logic clk_i, rst_i, wr_i, rd_i, rd_seen, lvl, osc_run, osc;
   logic [7:0] addr_i;
   logic [15:0] wdata_i, rdata_o, e_v, p, hi, en, cc;
   logic chan1_output_o, output_drive_enable_o, update_event_o;
   logic [2:0] sel;
   logic [4:0] line;
   logic [31:0] rnd = 32'h8d47;
   logic [15:0] exp_q[$];
   int bad_count = 0;
   int num_checks = 0;
   localparam logic [7:0] OFFS [5] = '{timer_pkg::OFF_CHANNEL_ENABLE_POLARITY, timer_pkg::OFF_PRESCALE_DIVIDER,
      timer_pkg::OFF_RELOAD_VALUE, timer_pkg::OFF_CHANNEL1_VALUE, timer_pkg::OFF_INPUT_REMAP_OPTION};
   localparam logic [15:0] RSTS [5] = '{16'h0000, 16'h0000, 16'hffff, 16'h0000, 16'h0000};
   localparam logic [15:0] DIRS [5] = '{16'h0001, 16'h0002, 16'h0003, 16'h0001, 16'h0001};
   localparam logic [15:0] RMPS [5] = '{16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0003};

   single_channel_timer_regs DUT (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .chan1_pin_i(line[0]), .chan2_pin_i(line[1]),
      .internal_trigger_i(line[2]), .rtc_clock_source_i(line[3]), .external_oscillator_clock_i(osc),
      .clock_output_signal_i(line[4]), .chan1_output_o(chan1_output_o),
      .output_drive_enable_o(output_drive_enable_o), .update_event_o(update_event_o));
   pin_source src (.sel_i(sel), .lvl_i(lvl), .osc_run_i(osc_run), .line_o(line), .osc_o(osc));

   ////////////////////////////////////////////////////////////////////////////
   // Core clock, 100 ns period.
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   // Read data stands only in the cycle after the strobe, so it is compared mid-cycle there.
   always @(posedge clk_i) rd_seen <= rd_i;
   always @(negedge clk_i) begin
      if (rd_seen === 1'b1) begin
         e_v = exp_q.pop_front();
         `CHK(rdata_o, e_v)
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus tasks, waits and measurements.
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic wreg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [15:0] x);
      exp_q.push_back(x);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(negedge clk_i);
   endtask

   // A missing update event is a mismatch rather than a hang.
   task automatic wait_upd;
      int i;
      i = 0;
      @(negedge clk_i);
      while (update_event_o !== 1'b1 && i < 3000) begin
         @(negedge clk_i);
         i++;
      end
      if (i >= 3000) begin
         bad_count++;
         $display("Error at %0t ns: no update event", $time);
      end
   endtask

   task automatic period(output logic [15:0] n);
      time t0;
      wait_upd;
      t0 = $time;
      wait_upd;
      n = 16'(($time - t0) / 100);
   endtask

   // Counts high output and drive-enable cycles over one counter period.
   task automatic measure;
      hi = 16'h0000;
      en = 16'h0000;
      wait_upd;
      repeat (10) begin
         hi = hi + 16'(chan1_output_o);
         en = en + 16'(output_drive_enable_o);
         @(negedge clk_i);
      end
   endtask

   // Loads a random frozen count, moves the selected source and reads the channel value.
   task automatic edge_cap(input logic l, input logic hit);
      rnd = lfsr(rnd);
      wreg(8'h24, rnd[15:0]);
      @(posedge clk_i);
      lvl <= l;
      repeat (8) @(posedge clk_i);
      if (hit) cc = rnd[15:0];
      rchk(8'h34, cc);
   endtask

   task automatic test_done;
      $display("Checks %0d, mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog, far beyond the several hundred cycles the sequence needs.
   initial begin
      repeat (20000) @(posedge clk_i);
      bad_count++;
      $display("Error at %0t ns: watchdog expired", $time);
      test_done;
   end

   // Main sequence.
   initial begin
      {rst_i, wr_i, rd_i, lvl, osc_run, addr_i, wdata_i, sel} = '0;
      rst_i = 1'b1;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int k = 0; k < 5; k++) rchk(OFFS[k], RSTS[k]);
      wreg(8'h40, 16'hffff);
      rchk(8'h40, 16'h0000);
      wreg(8'h18, 16'h0001);
      wreg(8'h20, 16'hffff);
      rchk(8'h20, 16'h000b);
      wreg(8'h20, 16'h0000);
      wreg(8'h50, 16'hffff);
      rchk(8'h50, 16'h0003);
      wreg(8'h50, 16'h0000);
      $display("test registers done");
      wreg(8'h24, 16'h0000);
      wreg(8'h2c, 16'h0009);
      period(p);
      `CHK(p, 16'd10)
      $display("test time base done");
      wreg(8'h18, 16'h0000);
      wreg(8'h34, 16'h0004);
      measure;
      `CHK(hi, 16'd0)
      `CHK(en, 16'd0)
      wreg(8'h20, 16'h0001);
      measure;
      `CHK(hi, 16'd4)
      `CHK(en, 16'd10)
      wreg(8'h20, 16'h0003);
      measure;
      `CHK(hi, 16'd6)
      wreg(8'h20, 16'h0001);
      wreg(8'h34, 16'h0007);
      rchk(8'h34, 16'h0007);
      measure;
      `CHK(hi, 16'd7)
      wreg(8'h18, 16'h0008);
      wait_upd;
      wreg(8'h34, 16'h0002);
      rchk(8'h34, 16'h0007);
      wait_upd;
      rchk(8'h34, 16'h0002);
      $display("test compare output done");
      cc = 16'h0002;
      wreg(8'h20, 16'h0000);
      wreg(8'h18, 16'h0001);
      wreg(8'h2c, 16'h0000);
      wreg(8'h20, 16'h0001);
      edge_cap(1'b1, 1'b1);
      edge_cap(1'b0, 1'b0);
      wreg(8'h20, 16'h0000);
      edge_cap(1'b1, 1'b0);
      edge_cap(1'b0, 1'b0);
      wreg(8'h20, 16'h0003);
      edge_cap(1'b1, 1'b0);
      edge_cap(1'b0, 1'b1);
      wreg(8'h20, 16'h000b);
      edge_cap(1'b1, 1'b1);
      edge_cap(1'b0, 1'b1);
      for (int k = 1; k < 5; k++) begin
         wreg(8'h20, 16'h0000);
         wreg(8'h18, DIRS[k]);
         wreg(8'h50, RMPS[k]);
         wreg(8'h20, 16'h0001);
         sel <= 3'(k);
         edge_cap(1'b1, 1'b1);
         edge_cap(1'b0, 1'b0);
      end
      wreg(8'h20, 16'h0000);
      wreg(8'h18, 16'h0001);
      wreg(8'h50, 16'h0002);
      wreg(8'h20, 16'h0001);
      rnd = lfsr(rnd);
      wreg(8'h24, rnd[15:0]);
      osc_run <= 1'b1;
      repeat (220) @(posedge clk_i);
      rchk(8'h34, rnd[15:0]);
      osc_run <= 1'b0;
      $display("test capture done");
      wreg(8'h20, 16'h0000);
      wreg(8'h24, 16'h0000);
      wreg(8'h2c, 16'h0004);
      wreg(8'h28, 16'h0003);
      wait_upd;
      period(p);
      `CHK(p, 16'd20)
      $display("test prescaler done");
      test_done;
   end
endmodule
